// ==== common/din_filter_map.svh ====
`ifndef DIN_FILTER_MAP_SVH
`define DIN_FILTER_MAP_SVH

// register byte offsets (one aligned word each)
`define REG_CTRL 8'h00
`define REG_COS_EN 8'h04
`define REG_RISE_DLY 8'h08
`define REG_FALL_DLY 8'h0C
`define REG_INTERVAL 8'h10
`define REG_PRESET 8'h14
`define REG_CNT_SEL 8'h18
`define REG_STATE 8'h1C
`define REG_COUNT 8'h20
`define REG_STATUS 8'h24

// control and status fields
`define CTRL_CNT_EN_BIT 0
`define CTRL_CNT_CLR_BIT 1
`define STATUS_OVF_BIT 0
`define STATUS_DONE_BIT 1

// reset values
`define COS_EN_RESET 16'hFFFF
`define INTERVAL_RESET 32'h0000C350

// timing: filter delays are written in microseconds
`define CLK_MHZ 20
`define FILTER_MAX_US 50000
`define US_CYCLES `CLK_MHZ

`endif

// ==== common/din_filter_pkg.sv ====
package din_filter_pkg;
    // request to the report link
    typedef struct packed {
        logic valid;
        logic change_of_state_report;
        logic [15:0] state;
    } report_type;
endpackage : din_filter_pkg

// ==== verilog/din_filter.sv ====
// Function
// - send filtered input state every requested packet interval, always
// - extra report when an enabled point's filtered state changes
// - change-of-state reporting enabled for every point after reset
// - separate programmable off-to-on and on-to-off filter delays
// - each filter delay settable from 0 us up to 50 ms
// - simple count mode counts filtered pulses up to 30 kHz
// - count compared to preset; count at or above preset drives an associated output
// - counter counts up only and flags overflow past its maximum
// - six or sixteen points, each with own filter and reporting
//
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`include "din_filter_map.svh"
module din_filter
    import din_filter_pkg::*;
#(
    parameter int POINTS = 16,
    parameter int CNT_W = 32
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // field inputs
    input wire logic [POINTS-1:0] raw_i,
    // report link and counter output
    output report_type report_o,
    output logic cnt_out_o
);
    localparam int DLY_W = 20;
    localparam logic [DLY_W-1:0] DLY_MAX = DLY_W'(`FILTER_MAX_US * `US_CYCLES);

    logic [15:0] cos_en_reg;
    logic [DLY_W-1:0] rise_dly_reg, fall_dly_reg;
    logic [31:0] interval_reg, interval_cnt_reg;
    logic [CNT_W-1:0] preset_reg, count_reg;
    logic [3:0] cnt_sel_reg;
    logic cnt_en_reg, ovf_reg, done_reg;
    wire logic [POINTS-1:0] filt_reg;
    logic [15:0] filt_ext;
    logic [POINTS-1:0] change;
    logic wr, rd;
    logic cnt_clr;
    logic [31:0] ctrl_word, cos_word, dly_word, interval_word, preset_word, sel_word;

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    assign filt_ext = 16'(filt_reg);

    // merge byte lanes of a write into an old word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [3:0] sel_v,
                                               input logic [31:0] dat_v);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel_v[b]) begin
                r[b*8 +: 8] = dat_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    // clamp a delay in microseconds to the supported range, in cycles
    function automatic logic [DLY_W-1:0] to_cycles(input logic [31:0] us);
        logic [31:0] u;
        u = (us > 32'(`FILTER_MAX_US)) ? 32'(`FILTER_MAX_US) : us;
        return DLY_W'(u * 32'(`US_CYCLES));
    endfunction : to_cycles

    // write words with the selected byte lanes merged in
    assign ctrl_word = lane_merge({31'h0, cnt_en_reg}, wb_sel_i, wb_dat_i);
    assign cos_word = lane_merge({16'h0, cos_en_reg}, wb_sel_i, wb_dat_i);
    assign dly_word = lane_merge(32'h0, wb_sel_i, wb_dat_i); // unselected lanes read as zero
    assign interval_word = lane_merge(interval_reg, wb_sel_i, wb_dat_i);
    assign preset_word = lane_merge(32'(preset_reg), wb_sel_i, wb_dat_i);
    assign sel_word = lane_merge({28'h0, cnt_sel_reg}, wb_sel_i, wb_dat_i);

    // ack one cycle after request; drops next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    // configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cos_en_reg <= `COS_EN_RESET;
            rise_dly_reg <= '0;
            fall_dly_reg <= '0;
            interval_reg <= `INTERVAL_RESET;
            preset_reg <= '0;
            cnt_sel_reg <= 4'h0;
            cnt_en_reg <= 1'b0;
        end else if (wr) begin
            case (wb_adr_i)
                `REG_CTRL: cnt_en_reg <= ctrl_word[`CTRL_CNT_EN_BIT];
                `REG_COS_EN: cos_en_reg <= cos_word[15:0];
                // the two directions are held apart
                `REG_RISE_DLY: rise_dly_reg <= to_cycles(dly_word);
                `REG_FALL_DLY: fall_dly_reg <= to_cycles(dly_word);
                `REG_INTERVAL: interval_reg <= interval_word;
                `REG_PRESET: preset_reg <= CNT_W'(preset_word);
                `REG_CNT_SEL: cnt_sel_reg <= sel_word[3:0];
                default: ;
            endcase
        end
    end

    // per point debounce; no checking of AC validity
    generate
        for (genvar p = 0; p < POINTS; p++) begin : g_point
            logic [DLY_W-1:0] hold_reg;
            logic level_reg;
            // one flop per point, gathered into the vector so each bit has one driver
            assign filt_reg[p] = level_reg;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    hold_reg <= '0;
                    level_reg <= 1'b0;
                end else if (raw_i[p] == level_reg) begin
                    hold_reg <= '0; // any bounce restarts the wait
                end else if (hold_reg >= (level_reg ? fall_dly_reg : rise_dly_reg)) begin
                    level_reg <= raw_i[p];
                    hold_reg <= '0;
                end else if (hold_reg < DLY_MAX) begin
                    hold_reg <= hold_reg + 1'b1;
                end
            end
        end
    endgenerate

    // change detect on filtered state for reporting
    logic [POINTS-1:0] filt_d_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filt_d_reg <= '0;
        end else begin
            filt_d_reg <= filt_reg;
        end
    end
    assign change = filt_reg ^ filt_d_reg;

    // periodic and change-of-state reports
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            interval_cnt_reg <= '0;
            report_o <= '0;
        end else begin
            report_o.state <= filt_ext;
            report_o.valid <= 1'b0;
            report_o.change_of_state_report <= 1'b0;
            if (interval_cnt_reg + 32'h1 >= interval_reg) begin
                interval_cnt_reg <= '0;
                report_o.valid <= 1'b1;
            end else begin
                interval_cnt_reg <= interval_cnt_reg + 32'h1;
            end
            if (|(change & cos_en_reg[POINTS-1:0])) begin
                report_o.valid <= 1'b1;
                report_o.change_of_state_report <= 1'b1;
            end
        end
    end

    // simple up counter on the selected filtered point
    logic cnt_edge;
    assign cnt_edge = filt_ext[cnt_sel_reg] && !change[cnt_sel_reg] ? 1'b0
                      : filt_ext[cnt_sel_reg]; // rising edge of filtered input
    assign cnt_clr = wr && wb_adr_i == `REG_CTRL && wb_sel_i[0] && wb_dat_i[`CTRL_CNT_CLR_BIT];
    // a clear in the wrap cycle loses that pulse but never the overflow flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= '0;
            ovf_reg <= 1'b0;
        end else begin
            if (cnt_clr) begin
                count_reg <= '0;
                ovf_reg <= 1'b0;
            end else if (cnt_en_reg && cnt_edge) begin
                count_reg <= count_reg + 1'b1;
            end
            if (cnt_en_reg && cnt_edge && (&count_reg)) begin
                ovf_reg <= 1'b1; // wrap past maximum, set wins
            end
        end
    end

    // preset compare drives the associated output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_reg <= 1'b0;
            cnt_out_o <= 1'b0;
        end else begin
            done_reg <= cnt_en_reg && (count_reg >= preset_reg);
            cnt_out_o <= cnt_en_reg && (count_reg >= preset_reg);
        end
    end

    // read mux, registered with the ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (rd) begin
            case (wb_adr_i)
                `REG_CTRL: wb_dat_o <= {31'h0, cnt_en_reg};
                `REG_COS_EN: wb_dat_o <= {16'h0, cos_en_reg};
                `REG_RISE_DLY: wb_dat_o <= 32'(rise_dly_reg / DLY_W'(`US_CYCLES));
                `REG_FALL_DLY: wb_dat_o <= 32'(fall_dly_reg / DLY_W'(`US_CYCLES));
                `REG_INTERVAL: wb_dat_o <= interval_reg;
                `REG_PRESET: wb_dat_o <= 32'(preset_reg);
                `REG_CNT_SEL: wb_dat_o <= {28'h0, cnt_sel_reg};
                `REG_STATE: wb_dat_o <= {16'h0, filt_ext};
                `REG_COUNT: wb_dat_o <= 32'(count_reg);
                `REG_STATUS: wb_dat_o <= {30'h0, done_reg, ovf_reg};
                default: wb_dat_o <= 32'h0;
            endcase
        end else begin
            wb_dat_o <= 32'h0;
        end
    end
endmodule : din_filter

// ==== sim/report_sink.sv ====
`timescale 1ns/10ps
module report_sink
    import din_filter_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // report link from the input block
    input wire report_type report_i,
    // tallies for the bench
    output int rpt_cnt_o,
    output int cos_cnt_o,
    output logic [15:0] last_state_o
);
    // controller side only listens; it can never stall the block
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rpt_cnt_o <= 0;
            cos_cnt_o <= 0;
            last_state_o <= 16'h0;
        end else if (report_i.valid) begin
            rpt_cnt_o <= rpt_cnt_o + 1;
            cos_cnt_o <= cos_cnt_o + int'(report_i.change_of_state_report);
            last_state_o <= report_i.state;
        end
    end
endmodule : report_sink

// ==== sim/din_filter_chk.sv ====
`timescale 1ns/10ps
`include "din_filter_map.svh"
module din_filter_chk
    import din_filter_pkg::*;
#(parameter int POINTS = 16, parameter int CNT_W = 32) (
    // bus side
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // field and report side
    input wire logic [POINTS-1:0] raw_i,
    input wire report_type report_o,
    input wire logic cnt_out_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // helper terms
    wire logic req = wb_cyc_i & wb_stb_i & !wb_ack_o;
    wire logic [15:0] raw_w = 16'(raw_i);
    // copy of the report enables, followed from bus writes
    logic [15:0] cos_en_copy_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cos_en_copy_reg <= `COS_EN_RESET;
        end else if (req && wb_we_i && wb_adr_i == `REG_COS_EN) begin
            for (int b = 0; b < 2; b++) begin
                if (wb_sel_i[b]) begin
                    cos_en_copy_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                end
            end
        end
    end

    ack_resp_a: assert property (req |=> wb_ack_o) else $error("request not acked");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    ack_cause_a: assert property (wb_ack_o |-> $past(req)) else $error("ack without request");
    rd_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
    cos_valid_a: assert property (
        report_o.change_of_state_report |-> report_o.valid) else $error("cos flag without report");
    cos_after_a: assert property (
        |((report_o.state ^ $past(report_o.state)) & $past(cos_en_copy_reg))
        |-> ##[0:3] (report_o.valid && report_o.change_of_state_report))
        else $error("state change not reported");
    cos_cause_a: assert property (
        report_o.change_of_state_report |-> |((report_o.state ^ $past(report_o.state)) & $past(cos_en_copy_reg)))
        else $error("cos flag without enabled change");
    flt_hold_a: assert property (
        $changed(report_o.state) |-> ((report_o.state ^ $past(report_o.state))
        & (report_o.state ^ $past(raw_w, 2))) == 16'h0) else $error("state left raw level");
    rst_quiet_a: assert property (disable iff (1'b0)
        rst_i |=> !wb_ack_o && !report_o.valid && !cnt_out_o) else $error("busy in reset");
    // main scenarios
    cover property (report_o.valid && report_o.change_of_state_report);
    cover property (report_o.valid && !report_o.change_of_state_report);
    cover property (cnt_out_o);
    cover property (wb_ack_o && wb_we_i);
endmodule : din_filter_chk

// ==== sim/din_filter_test.sv ====
`timescale 1ns/10ps
`include "din_filter_map.svh"
module din_filter_test;
    import din_filter_pkg::*;
    // stimulus and observed signals
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, wb_ack_o, cnt_out_o;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] dat = 32'h0, q, wb_dat_o;
    logic [15:0] raw_i = 16'h0, r, last_state;
    report_type report_o;
    int error_cnt = 0, num_checks = 0, seed = 32'h2CB6F94F, rpt_cnt, cos_cnt, n0, c0;
    always #25 clk_i = ~clk_i;
    // two-bit count so the wrap comes quickly
    din_filter #(.POINTS(16), .CNT_W(2)) u_din_filter (.clk_i, .rst_i, .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o, .wb_ack_o, .raw_i, .report_o, .cnt_out_o);
    report_sink u_report_sink (.clk_i, .rst_i, .report_i(report_o), .rpt_cnt_o(rpt_cnt),
        .cos_cnt_o(cos_cnt), .last_state_o(last_state));
    // one classic cycle; waits on ack, watchdog cuts a hang
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {cyc, stb} <= 2'b00;
    endtask : wb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd
    // delay readback: writes beyond the longest filter are clamped
    function automatic logic [31:0] exp_dly(input logic [31:0] us);
        return (us > 32'(`FILTER_MAX_US)) ? 32'(`FILTER_MAX_US) : us;
    endfunction : exp_dly
    task automatic conclude;
        if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    // watchdog, well past the few thousand cycles needed
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        conclude;
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`REG_COS_EN, 32'h0000FFFF);
        rd(`REG_INTERVAL, 32'h0000C350);
        rd(8'h40, 32'h0);
        wb(1'b1, `REG_RISE_DLY, 32'h0000EA60);
        rd(`REG_RISE_DLY, exp_dly(32'h0000EA60));
        wb(1'b1, `REG_RISE_DLY, 32'h2);
        wb(1'b1, `REG_FALL_DLY, 32'h5);
        rd(`REG_FALL_DLY, exp_dly(32'h5));
        wb(1'b1, `REG_INTERVAL, 32'hC8);
        repeat (200) @(posedge clk_i);
        n0 = rpt_cnt;
        c0 = cos_cnt;
        repeat (2000) @(posedge clk_i);
        chk(32'(rpt_cnt - n0 inside {[9:11]}), 32'h1);
        chk(cos_cnt - c0, 32'h0);
        // glitches shorter than 41 cycles never reach the state
        repeat (4) begin
            raw_i <= 16'($random(seed));
            repeat (1 + {$random(seed)} % 30) @(posedge clk_i);
            raw_i <= 16'h0;
            @(posedge clk_i);
        end
        rd(`REG_STATE, 32'h0);
        r = 16'($random(seed)) | 16'h0001;
        c0 = cos_cnt;
        raw_i <= r;
        repeat (35) @(posedge clk_i);
        rd(`REG_STATE, 32'h0);
        repeat (10) @(posedge clk_i);
        rd(`REG_STATE, {16'h0, r});
        chk({16'h0, last_state}, {16'h0, r});
        raw_i <= 16'h0;
        repeat (90) @(posedge clk_i);
        rd(`REG_STATE, {16'h0, r});
        repeat (12) @(posedge clk_i);
        rd(`REG_STATE, 32'h0);
        chk(cos_cnt - c0, 32'h2);
        // counter on point 0, preset 3, wraps on the fourth pulse
        wb(1'b1, `REG_CNT_SEL, 32'h0);
        wb(1'b1, `REG_PRESET, 32'h3);
        wb(1'b1, `REG_CTRL, 32'h1);
        for (int i = 1; i <= 4; i++) begin
            raw_i <= 16'h0001;
            repeat (50) @(posedge clk_i);
            raw_i <= 16'h0;
            repeat (110) @(posedge clk_i);
            rd(`REG_COUNT, i % 4);
            chk(cnt_out_o, i == 3);
        end
        rd(`REG_STATUS, 32'h1);
        wb(1'b1, `REG_CTRL, 32'h3);
        rd(`REG_COUNT, 32'h0);
        rd(`REG_STATUS, 32'h0);
        // reports off for every point: a filtered change stays quiet
        wb(1'b1, `REG_COS_EN, 32'h0);
        c0 = cos_cnt;
        raw_i <= 16'h0001;
        repeat (60) @(posedge clk_i);
        rd(`REG_STATE, 32'h1);
        chk(cos_cnt - c0, 32'h0);
        // reset in mid-run brings the report enables back
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`REG_COS_EN, 32'h0000FFFF);
        wb(1'b1, `REG_RISE_DLY, 32'h0);
        rd(`REG_STATE, 32'h1);
        conclude;
    end
endmodule : din_filter_test
bind din_filter din_filter_chk #(.POINTS(POINTS), .CNT_W(CNT_W)) u_din_filter_chk (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .raw_i, .report_o, .cnt_out_o);
